// ---- hw/slpc_defs.svh ----
// Bit positions, select codes and timing counts for the synthesizer latch bank
`ifndef SLPC_DEFS_SVH
`define SLPC_DEFS_SVH
`define SLPC_WORD_W        24
`define SLPC_SEL_CTRL      2'h0
`define SLPC_SEL_REF       2'h1
`define SLPC_SEL_FB        2'h2
`define SLPC_SEL_TEST      2'h3
`define SLPC_PRESC_HI      23
`define SLPC_PRESC_LO      22
`define SLPC_PD_STYLE      21
`define SLPC_PD_REQ        20
`define SLPC_PUMP_TRI      9
`define SLPC_CNT_CLEAR     4
`define SLPC_BAND_CYCLES   3'h5
`define SLPC_CFG_RESET     24'h000000
`endif

// ---- hw/slpc_pkg.sv ----
// Types shared by the synthesizer latch bank
package slpc_pkg;
	typedef enum logic [3:0] {
		SLPC_OFF     = 4'h1,
		SLPC_RUN     = 4'h2,
		SLPC_ARMED   = 4'h4,
		SLPC_PWRDN   = 4'h8
	} slpc_pwr_t;
endpackage : slpc_pkg

// ---- hw/slpc_sync.sv ----
// Two-flop level synchroniser
`timescale 1ns/1ps
module slpc_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Level in and out
	input  wire logic d,
	output logic      q
);
	logic meta_r;

	// Only q reads the first stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : slpc_sync

// ---- hw/slpc_top.sv ----
// Serial latch bank and power management of the synthesizer
// Function
// (RULE1) Shift 24 bits MSB first on serial clock rise; latch on strobe rise.
// (RULE2) Select bits 00 route the word to the control latch.
// (RULE3) Select bits 10 route the word to the feedback divider latch.
// (RULE4) Select bits 01 route the word to the reference divider latch.
// (RULE5) Prescaler ratio comes from control word bits 23 and 22.
// (RULE6) Control bit 21 picks power-down style, bit 20 requests power-down.
// (RULE7) Request with style zero powers down immediately on latching.
// (RULE8) Both bits set: power down on second reference tick after strobe.
// (RULE9) Chip enable low disables the device at once.
// (RULE10) Power-down holds dividers and timeout counters in load state.
// (RULE11) Power-down three-states the charge pump.
// (RULE12) Power-down clears digital lock detect.
// (RULE13) Power-down debiases RF outputs, disables reference buffer, removes currents.
// (RULE14) Serial register keeps shifting and latching during power-down.
// (RULE15) Host programs reference, then control, then feedback latch after power-up.
// (RULE16) First control write powers up and starts bias settling.
// (RULE17) Host waits 5 ms or 600 us between control and feedback words.
// (RULE18) Power-up without feedback rewrite keeps the old band, no new selection.
// (RULE19) Host avoids feedback rewrite in power-down, else repeats full sequence.
// (RULE20) Band selection runs at power-up and feedback writes, five detector cycles.
// (RULE21) Latches hold until matching select; select 11 goes to an unused test latch.
`timescale 1ns/1ps
`include "slpc_defs.svh"
module slpc_top (
	// System clock and reset
	input  wire logic        clock,
	input  wire logic        resetn,
	// Three-wire link, serial clock domain
	input  wire logic        serial_clk,
	input  wire logic        serial_data,
	input  wire logic        latch_strobe,
	// Chip enable pin and reference divider output tick
	input  wire logic        chip_enable,
	input  wire logic        ref_div_out,
	// Latch contents
	output logic [23:0]      device_config_word,
	output logic [23:0]      feedback_divider_word,
	output logic [23:0]      reference_divider_word,
	output logic [1:0]       prescaler_ratio,
	// Power side effects
	output logic             powered_down,
	output logic             dividers_load,
	output logic             pump_three_state,
	output logic             lock_detect_clear,
	output logic             rf_bias_off,
	output logic             ref_buffer_off,
	output logic             band_select_active
);
	// Reset release
	logic rst_sync_a_r;
	logic rst_n;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_sync_a_r <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_sync_a_r <= 1'b1;
			rst_n        <= rst_sync_a_r;
		end
	end

	// Serial shift register, link clock domain; keeps running in power-down
	logic [23:0] shift_r;
	always_ff @(posedge serial_clk or negedge resetn) begin
		if (!resetn) begin
			shift_r <= 24'h000000;
		end else begin
			shift_r <= {shift_r[22:0], serial_data}; // RULE1 RULE14
		end
	end

	// Strobe side: capture word and toggle to hand over; host must not clock during strobe
	logic [23:0] hold_r;
	logic        hold_tgl_r;
	always_ff @(posedge latch_strobe or negedge resetn) begin
		if (!resetn) begin
			hold_r     <= 24'h000000;
			hold_tgl_r <= 1'b0;
		end else begin
			hold_r     <= shift_r; // RULE1
			hold_tgl_r <= ~hold_tgl_r;
		end
	end

	// Crossings into the system clock
	logic tgl_s;
	logic ce_s;
	logic ref_s;
	slpc_sync u_sync_tgl (.clk(clock), .rst_n(rst_n), .d(hold_tgl_r), .q(tgl_s));
	slpc_sync u_sync_ce  (.clk(clock), .rst_n(rst_n), .d(chip_enable), .q(ce_s));
	slpc_sync u_sync_ref (.clk(clock), .rst_n(rst_n), .d(ref_div_out), .q(ref_s));

	// Edge detect on synchronised levels; hold_r is stable once toggle is seen
	logic tgl_d_r;
	logic ref_d_r;
	logic word_stb;
	logic ref_rise;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tgl_d_r <= 1'b0;
			ref_d_r <= 1'b0;
		end else begin
			tgl_d_r <= tgl_s;
			ref_d_r <= ref_s;
		end
	end
	assign word_stb = tgl_s ^ tgl_d_r;
	assign ref_rise = ref_s & ~ref_d_r;

	// Select decode
	logic [1:0] sel;
	logic       wr_ctrl;
	logic       wr_fb;
	logic       wr_ref;
	logic       wr_test;
	assign sel     = hold_r[1:0];
	assign wr_ctrl = word_stb && (sel == `SLPC_SEL_CTRL); // RULE2
	assign wr_fb   = word_stb && (sel == `SLPC_SEL_FB);   // RULE3
	assign wr_ref  = word_stb && (sel == `SLPC_SEL_REF);  // RULE4
	assign wr_test = word_stb && (sel == `SLPC_SEL_TEST); // RULE21

	// Latches hold until rewritten
	logic [23:0] test_word_r;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			device_config_word     <= `SLPC_CFG_RESET;
			feedback_divider_word  <= `SLPC_CFG_RESET;
			reference_divider_word <= `SLPC_CFG_RESET;
			test_word_r            <= `SLPC_CFG_RESET;
		end else begin
			if (wr_ctrl) begin
				device_config_word <= hold_r; // RULE2 RULE21
			end
			if (wr_fb) begin
				feedback_divider_word <= hold_r; // RULE3 RULE21
			end
			if (wr_ref) begin
				reference_divider_word <= hold_r; // RULE4 RULE21
			end
			if (wr_test) begin
				test_word_r <= hold_r; // RULE21
			end
		end
	end
	// Test latch is kept but steers nothing
	assign prescaler_ratio = device_config_word[`SLPC_PRESC_HI:`SLPC_PRESC_LO]; // RULE5

	// Power state machine
	slpc_pkg::slpc_pwr_t pwr_r;
	logic [1:0]          ref_cnt_r;
	logic                new_req;
	logic                new_style;
	assign new_req   = hold_r[`SLPC_PD_REQ];   // RULE6
	assign new_style = hold_r[`SLPC_PD_STYLE]; // RULE6
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pwr_r     <= slpc_pkg::SLPC_OFF;
			ref_cnt_r <= 2'h0;
		end else begin
			case (pwr_r)
				slpc_pkg::SLPC_OFF: begin
					if (wr_ctrl && !new_req) begin
						pwr_r <= slpc_pkg::SLPC_RUN; // RULE16
					end
				end
				slpc_pkg::SLPC_RUN: begin
					if (wr_ctrl && new_req && !new_style) begin
						pwr_r <= slpc_pkg::SLPC_PWRDN; // RULE7
					end else if (wr_ctrl && new_req && new_style) begin
						pwr_r     <= slpc_pkg::SLPC_ARMED; // RULE8
						ref_cnt_r <= 2'h0;
					end
				end
				slpc_pkg::SLPC_ARMED: begin
					if (wr_ctrl && !new_req) begin
						pwr_r <= slpc_pkg::SLPC_RUN;
					end else if (wr_ctrl && !new_style) begin
						pwr_r <= slpc_pkg::SLPC_PWRDN; // RULE7
					end else if (ref_rise) begin
						if (ref_cnt_r == 2'h1) begin
							pwr_r <= slpc_pkg::SLPC_PWRDN; // RULE8
						end
						ref_cnt_r <= ref_cnt_r + 2'h1;
					end
				end
				slpc_pkg::SLPC_PWRDN: begin
					if (wr_ctrl && !new_req) begin
						pwr_r <= slpc_pkg::SLPC_RUN; // RULE18
					end
				end
				default: begin
					pwr_r <= slpc_pkg::SLPC_OFF;
				end
			endcase
		end
	end

	// Chip enable overrides everything, combinationally after sync
	logic down;
	assign down = (pwr_r != slpc_pkg::SLPC_RUN && pwr_r != slpc_pkg::SLPC_ARMED) || !ce_s; // RULE9

	// Band selection: needs a new feedback word or the first power-up
	logic       band_chosen_r;
	logic       band_req_r;
	logic [2:0] band_cnt_r;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			band_chosen_r <= 1'b0;
			band_req_r    <= 1'b0;
			band_cnt_r    <= 3'h0;
		end else begin
			if (wr_fb && !down) begin
				band_cnt_r <= `SLPC_BAND_CYCLES; // RULE20
				band_req_r <= 1'b0; // New word restarts any run at once
			end else if (wr_fb) begin
				band_req_r <= 1'b1; // RULE20
				band_cnt_r <= 3'h0; // Deferred until power returns
			end else if (!down && band_cnt_r == 3'h0 && (band_req_r || !band_chosen_r)) begin
				band_cnt_r <= `SLPC_BAND_CYCLES; // RULE20
				band_req_r <= 1'b0;
			end else if (down) begin
				band_cnt_r <= 3'h0; // Aborted run restarts on power-up only if no band has been chosen yet
			end else if (band_cnt_r != 3'h0 && ref_rise) begin
				band_cnt_r <= band_cnt_r - 3'h1;
				if (band_cnt_r == 3'h1) begin
					band_chosen_r <= 1'b1; // RULE18
				end
			end
		end
	end
	assign band_select_active = (band_cnt_r != 3'h0);

	// Power-down side effects, registered
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			powered_down      <= 1'b1;
			dividers_load     <= 1'b1;
			pump_three_state  <= 1'b1;
			lock_detect_clear <= 1'b1;
			rf_bias_off       <= 1'b1;
			ref_buffer_off    <= 1'b1;
		end else begin
			powered_down      <= down;
			dividers_load     <= down || device_config_word[`SLPC_CNT_CLEAR];   // RULE10
			pump_three_state  <= down || device_config_word[`SLPC_PUMP_TRI];    // RULE11
			lock_detect_clear <= down;                                          // RULE12
			rf_bias_off       <= down;                                          // RULE13
			ref_buffer_off    <= down;                                          // RULE13
		end
	end

	// Checks: routing and holding of the latches
	// Control word lands one cycle after its strobe
	ctrl_route_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE2
		wr_ctrl |=> device_config_word == $past(hold_r)) else $error("control latch not loaded");
	// Feedback word lands one cycle after its strobe
	fb_route_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
		wr_fb |=> feedback_divider_word == $past(hold_r)) else $error("feedback latch not loaded");
	// Reference word lands one cycle after its strobe
	ref_route_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE4
		wr_ref |=> reference_divider_word == $past(hold_r)) else $error("reference latch not loaded");
	// Control latch untouched by other words
	latch_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE21
		!wr_ctrl |=> $stable(device_config_word)) else $error("control latch changed");
	// Feedback latch untouched by other words
	fb_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE21
		!wr_fb |=> $stable(feedback_divider_word)) else $error("feedback latch changed");
	// Reference latch untouched by other words
	ref_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE21
		!wr_ref |=> $stable(reference_divider_word)) else $error("reference latch changed");
	// Test words must leave every visible latch alone
	test_quiet_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE21
		wr_test |=> $stable(device_config_word) && $stable(feedback_divider_word) && $stable(reference_divider_word))
		else $error("test word leaked into a latch");
	// Prescaler field taken from the top two bits
	presc_map_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
		prescaler_ratio == device_config_word[23:22]) else $error("prescaler bits wrong");

	// Checks: power state
	// First clean control word wakes the device
	pwr_up_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE16
		(pwr_r == slpc_pkg::SLPC_OFF && wr_ctrl && !new_req) |=> pwr_r == slpc_pkg::SLPC_RUN)
		else $error("first control word did not power up");
	// Running with the pin high means outputs active
	run_up_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE16
		(pwr_r == slpc_pkg::SLPC_RUN && ce_s) |=> !powered_down) else $error("running but powered down");
	// Asynchronous style drops two cycles after the strobe
	async_pd_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE7
		(pwr_r == slpc_pkg::SLPC_RUN && wr_ctrl && new_req && !new_style) |=> ##1 powered_down)
		else $error("async power-down late");
	// Arming clears the tick count, so old ticks never count
	ref_cnt_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
		(pwr_r == slpc_pkg::SLPC_RUN && wr_ctrl && new_req && new_style)
		|=> pwr_r == slpc_pkg::SLPC_ARMED && ref_cnt_r == 2'h0) else $error("sync power-down not armed");
	// No power-down on the first tick
	armed_wait_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
		(pwr_r == slpc_pkg::SLPC_ARMED && ref_cnt_r == 2'h0 && !word_stb) |=> pwr_r != slpc_pkg::SLPC_PWRDN)
		else $error("sync power-down too early");
	// Power-down exactly on the second tick
	sync_pd_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE8
		(pwr_r == slpc_pkg::SLPC_ARMED && ref_cnt_r == 2'h1 && ref_rise && !word_stb)
		|=> pwr_r == slpc_pkg::SLPC_PWRDN) else $error("sync power-down missed second tick");
	// Pin low wins over any programmed state
	ce_off_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE9
		!ce_s |=> powered_down && rf_bias_off) else $error("chip enable ignored");
	// All side effects but rf_bias_off accompany power-down
	pd_effects_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE10 RULE11 RULE12 RULE13
		powered_down |-> dividers_load && pump_three_state && lock_detect_clear && ref_buffer_off)
		else $error("power-down effects missing");
	// Reference words still latch while powered down
	pd_serial_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE14
		(powered_down && wr_ref) |=> reference_divider_word == $past(hold_r))
		else $error("latching stopped in power-down");

	// Checks: band selection
	// Every run starts at the full length
	band_len_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE20
		$rose(band_select_active) |-> band_cnt_r == 3'h5) else $error("band run length wrong");
	// A feedback write while running restarts the run
	fb_band_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE20
		(wr_fb && !down) |=> band_cnt_r == 3'h5) else $error("feedback write did not start band run");
	// Band counter held in load state while down
	band_abort_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE10
		down |=> !band_select_active) else $error("band run continued in power-down");
	// Waking without a new feedback word keeps the band
	band_keep_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE18
		(pwr_r == slpc_pkg::SLPC_PWRDN && wr_ctrl && !new_req && band_chosen_r && !band_req_r)
		|=> ##2 !band_select_active) else $error("band reselected without new feedback word");

	// Main scenarios reached
	cover_async_c: cover property (@(posedge clock) disable iff (!rst_n) pwr_r == slpc_pkg::SLPC_PWRDN);
	cover_armed_c: cover property (@(posedge clock) disable iff (!rst_n) pwr_r == slpc_pkg::SLPC_ARMED);
	cover_band_c: cover property (@(posedge clock) disable iff (!rst_n) $fell(band_select_active));
	cover_ce_c: cover property (@(posedge clock) disable iff (!rst_n) !ce_s && pwr_r == slpc_pkg::SLPC_RUN);
	cover_restart_c: cover property (@(posedge clock) disable iff (!rst_n) wr_fb && band_select_active);
endmodule : slpc_top

// ---- tb/slpc_host_model.sv ----
// Host model driving the three-wire programming link
`timescale 1ns/1ps
module slpc_host_model (
	// Three-wire link
	output logic serial_clk,
	output logic serial_data,
	output logic latch_strobe
);
	// Link idles with clock and strobe low
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		latch_strobe = 1'b0;
	end
	// One word MSB first, then strobe; clock stands still between frames
	task automatic send_word(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			serial_data = w[i];
			#62.5 serial_clk = 1'b1;
			#62.5 serial_clk = 1'b0;
		end
		// Inverted last bit, so a stale data level never looks valid
		serial_data = ~w[0];
		#62.5 latch_strobe = 1'b1;
		#125 latch_strobe = 1'b0;
		#62.5;
	endtask : send_word
endmodule : slpc_host_model

// ---- tb/tb_synth_latch_power_control.sv ----
// Testbench of the synthesizer latch bank and power management
`timescale 1ns/1ps
`include "slpc_defs.svh"
module tb_synth_latch_power_control;
	logic        clock = 1'b0;
	logic        resetn = 1'b0;
	logic        chip_enable = 1'b1;
	logic        ref_div_out = 1'b0;
	logic        ref_en = 1'b0;
	logic [3:0]  ref_ph = 4'h0;
	int          rise_cnt = 0;
	int          base;
	int          err_total = 0;
	int          check_count = 0;
	logic        serial_clk, serial_data, latch_strobe;
	logic [23:0] cfg_w, fb_w, ref_w, e_cfg, e_fb, e_ref;
	logic [1:0]  presc;
	logic        pd, dl, pt, lc, rb, rbo, band;

	always #5 clock = ~clock;
	// Reference tick every 16 clocks, only when enabled, so counts are exact
	always @(posedge clock) begin
		ref_ph <= ref_en ? ref_ph + 4'h1 : 4'h0;
		ref_div_out <= ref_en & ref_ph[3];
		if (ref_en && ref_ph == 4'h8)
			rise_cnt <= rise_cnt + 1;
	end

	slpc_host_model host (.serial_clk(serial_clk), .serial_data(serial_data), .latch_strobe(latch_strobe));
	slpc_top dut (.clock(clock), .resetn(resetn), .serial_clk(serial_clk), .serial_data(serial_data),
		.latch_strobe(latch_strobe), .chip_enable(chip_enable), .ref_div_out(ref_div_out),
		.device_config_word(cfg_w), .feedback_divider_word(fb_w), .reference_divider_word(ref_w),
		.prescaler_ratio(presc), .powered_down(pd), .dividers_load(dl), .pump_three_state(pt),
		.lock_detect_clear(lc), .rf_bias_off(rb), .ref_buffer_off(rbo), .band_select_active(band));

	// Pump and counter-clear bits low, so power outputs show power-down alone
	function automatic logic [23:0] mk(input logic [23:0] r, input logic [1:0] sel, input logic [1:0] pdb);
		mk = {r[23:22], pdb, r[19:10], 1'b0, r[8:5], 1'b0, r[3:2], sel};
	endfunction : mk

	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic clks(input int n);
		repeat (n) @(posedge clock);
	endtask : clks

	// Expected latch follows the select code; the three visible latches compared after, not the test latch
	task automatic wr(input logic [23:0] w);
		case (w[1:0])
			2'h0: e_cfg = w;
			2'h1: e_ref = w;
			2'h2: e_fb = w;
			default: ;
		endcase
		host.send_word(w);
		clks(8);
		chk("config", e_cfg, cfg_w);
		chk("feedback", e_fb, fb_w);
		chk("reference", e_ref, ref_w);
		chk("prescaler", {22'h0, e_cfg[23:22]}, {22'h0, presc});
	endtask : wr

	task automatic chk_pwr(input logic e);
		chk("power", {18'h0, {6{e}}}, {18'h0, pd, dl, pt, lc, rb, rbo});
	endtask : chk_pwr

	task automatic wait_pd(input int n);
		for (int i = 0; i < n && pd !== 1'b1; i++)
			@(posedge clock);
	endtask : wait_pd

	task automatic wait_band(input int n);
		for (int i = 0; i < n && band !== 1'b0; i++)
			@(posedge clock);
	endtask : wait_band

	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop

	// Watchdog sized above the settling wait plus all frames
	initial begin
		#900_000;
		err_total++;
		report_and_stop();
	end

	initial begin
		void'($urandom(78));
		e_cfg = 24'h0;
		e_fb = 24'h0;
		e_ref = 24'h0;
		clks(16);
		resetn <= 1'b1;
		clks(4);
		chk_pwr(1'b1);
		wr(mk(24'($urandom), `SLPC_SEL_REF, 2'h0));
		chk_pwr(1'b1);
		wr(mk(24'($urandom), `SLPC_SEL_CTRL, 2'h0));
		chk_pwr(1'b0);
		chk("band on", 24'h1, {23'h0, band});
		clks(60000);
		wr(mk(24'($urandom), `SLPC_SEL_FB, 2'h0));
		base = rise_cnt;
		ref_en <= 1'b1;
		wait_band(200);
		chk("band ticks", 24'h5, 24'(rise_cnt - base));
		ref_en <= 1'b0;
		wr(mk(24'($urandom), `SLPC_SEL_TEST, 2'h0));
		// Synchronous style: nothing until two reference rises arrive
		wr(mk(24'($urandom), `SLPC_SEL_CTRL, 2'h3));
		clks(20);
		chk_pwr(1'b0);
		base = rise_cnt;
		ref_en <= 1'b1;
		wait_pd(100);
		chk("sync ticks", 24'h2, 24'(rise_cnt - base));
		clks(2);
		chk_pwr(1'b1);
		ref_en <= 1'b0;
		wr(mk(24'($urandom), `SLPC_SEL_REF, 2'h3));
		wr(mk(24'($urandom), `SLPC_SEL_CTRL, 2'h0));
		chk_pwr(1'b0);
		clks(30);
		chk("band kept", 24'h0, {23'h0, band});
		wr(mk(24'($urandom), `SLPC_SEL_CTRL, 2'h1));
		chk_pwr(1'b1);
		wr(mk(24'($urandom), `SLPC_SEL_CTRL, 2'h0));
		chip_enable <= 1'b0;
		clks(5);
		chk_pwr(1'b1);
		chip_enable <= 1'b1;
		clks(8);
		chk_pwr(1'b0);
		chk("band pin", 24'h0, {23'h0, band});
		for (int i = 0; i < 6; i++)
			wr(mk(24'($urandom), 2'($urandom_range(0, 3)), 2'h0));
		report_and_stop();
	end
endmodule : tb_synth_latch_power_control
